// [arb_pkg.sv]
// shared constants and types for the four-processor bus arbiter and its processor end
package arb_pkg;

   // ****************************************************************
   // bus shape
   // ****************************************************************
   localparam int NUM_PROC = 4;
   localparam int DATA_W   = 24;
   localparam int SLOT_W   = 2;
   localparam int DIV_W    = 11;
   localparam int DLY_W    = 5;

   // one-hot grant codes, bit 0 is processor 1
   localparam logic [NUM_PROC-1:0] GRANT_NONE = 4'h0;
   localparam logic [NUM_PROC-1:0] GRANT_P1   = 4'h1;

   // transfer service order, slot 0 first: processor 2, 3, 4, then 1
   localparam logic [SLOT_W-1:0] SLOT_FIRST = 2'h0;
   localparam logic [SLOT_W-1:0] SLOT_LAST  = 2'h3;
   localparam logic [SLOT_W-1:0] SLOT_STEP  = 2'h1;
   localparam logic [SLOT_W-1:0] IDX_P1     = 2'h0;
   localparam logic [SLOT_W-1:0] IDX_P2     = 2'h1;
   localparam logic [SLOT_W-1:0] IDX_P3     = 2'h2;
   localparam logic [SLOT_W-1:0] IDX_P4     = 2'h3;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int CLK_HZ        = 20_000_000;
   localparam int CLK_PERIOD_NS = 50;
   localparam int TICK_HZ       = 16_000;
   localparam int RST_DLY_NS    = 1000;
   // longest-time divider rounds down, least-time delay rounds up
   localparam int TICK_DIV_CYC  = CLK_HZ / TICK_HZ;
   localparam int RST_DLY_CYC   = (RST_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [DIV_W-1:0] TICK_DIV_LAST = DIV_W'(TICK_DIV_CYC - 1);
   localparam logic [DLY_W-1:0] RST_DLY_LAST  = DLY_W'(RST_DLY_CYC - 1);
   localparam logic [DIV_W-1:0] DIV_ZERO      = 11'h000;
   localparam logic [DLY_W-1:0] DLY_ZERO      = 5'h00;
   localparam logic [DIV_W-1:0] DIV_ONE       = 11'h001;
   localparam logic [DLY_W-1:0] DLY_ONE       = 5'h01;

   // boot modes loaded once the reset gating delay ends
   localparam logic [3:0] BOOT_MODE_HOST = 4'h9;
   localparam logic [3:0] BOOT_MODE_NONE = 4'h0;

   // ****************************************************************
   // arbiter states
   // ****************************************************************
   typedef enum logic [2:0] {
      ST_NORMAL = 3'b001,
      ST_WAIT   = 3'b010,
      ST_SERVE  = 3'b100
   } arb_state_e;

endpackage

// [dsp_bus_if.sv]
// interface joining the bus arbiter and the four processor bus ports
`timescale 1ns/1ns
interface dsp_bus_if;
   import arb_pkg::*;

   logic [NUM_PROC-1:0]             bus_grant;
   logic [NUM_PROC-1:0]             grant_state_line;
   logic [NUM_PROC-1:0]             ownership_request_line;
   logic [NUM_PROC-1:0]             transfer_ready_line;
   logic                            sample_tick_interrupt;
   logic [NUM_PROC-1:0]             data_oe;
   logic [NUM_PROC-1:0][DATA_W-1:0] data_out;
   logic [DATA_W-1:0]               data_bus;

   // ****************************************************************
   // shared bus resolution
   // ****************************************************************
   // wired-or of enabled drivers; only one is ever enabled
   always_comb begin
      data_bus = '0;
      for (int i = 0; i < NUM_PROC; i++) begin
         if (data_oe[i]) begin
            data_bus = data_bus | data_out[i];
         end
      end
   end

   modport arbiter (
      output bus_grant,
      input  grant_state_line,
      input  ownership_request_line,
      input  transfer_ready_line,
      input  sample_tick_interrupt,
      input  data_bus
   );

   modport cores (
      input  bus_grant,
      output grant_state_line,
      output ownership_request_line,
      output transfer_ready_line,
      output sample_tick_interrupt,
      output data_oe,
      output data_out,
      input  data_bus
   );

endinterface

// [dsp_cores_end.sv]
// bus-side end of the four signal processors, with tick interrupt and boot strapping
`timescale 1ns/1ns
module dsp_cores_end
   import arb_pkg::*;
(
   input  wire logic                         REF_CLK,
   input  wire logic                         RST_N,
   dsp_bus_if.cores                          BUS,
   input  wire logic [NUM_PROC-1:0]          REQ,
   input  wire logic [NUM_PROC-1:0]          XFER_RDY,
   input  wire logic [NUM_PROC-1:0]          WR_EN,
   input  wire logic [NUM_PROC*DATA_W-1:0]   WR_DATA,
   input  wire logic                         P1_BOOT_HOST_SEL,
   output logic      [NUM_PROC-1:0]          HOST_ACK,
   output logic      [DATA_W-1:0]            RD_DATA,
   output logic                              TICK_IRQ,
   output logic      [3:0]                   BOOT_MODE_P234,
   output logic                              P1_BOOT_HOST,
   output logic                              BOOT_DONE
);

   logic [NUM_PROC-1:0]             req_q;
   logic [NUM_PROC-1:0]             rdy_q;
   logic [NUM_PROC-1:0]             ack_q;
   logic [NUM_PROC-1:0]             oe_q;
   logic [NUM_PROC-1:0][DATA_W-1:0] dout_q;
   logic [DIV_W-1:0]                div_q;
   logic [DLY_W-1:0]                dly_q;
   logic                            irq_en_q;
   logic                            tick_q;

   // ****************************************************************
   // bus handshake lines
   // ****************************************************************
   // software request and ready lines, plus the grant echo
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         req_q <= '0;
         rdy_q <= '0;
         ack_q <= '0;
      end else begin
         req_q <= REQ;                          // [R2]
         rdy_q <= XFER_RDY;                     // [R2]
         ack_q <= BUS.bus_grant;                // [R2]
      end
   end

   assign BUS.ownership_request_line = req_q;
   assign BUS.transfer_ready_line    = rdy_q;
   assign BUS.grant_state_line       = ack_q;

   // ****************************************************************
   // shared data bus drive
   // ****************************************************************
   // drive only while granted and still holding a line, so the drive
   // falls on the same edge as the line the arbiter watches
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         oe_q   <= '0;
         dout_q <= '0;
      end else begin
         for (int i = 0; i < NUM_PROC; i++) begin
            oe_q[i]   <= BUS.bus_grant[i] & WR_EN[i] & (REQ[i] | XFER_RDY[i]);  // [R1]
            dout_q[i] <= WR_DATA[i*DATA_W +: DATA_W];
         end
      end
   end

   assign BUS.data_oe  = oe_q;
   assign BUS.data_out = dout_q;

   // host acknowledge pins used as plain outputs echoing each request line
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         HOST_ACK <= '0;
         RD_DATA  <= '0;
      end else begin
         HOST_ACK <= req_q;                     // [R8]
         RD_DATA  <= BUS.data_bus;
      end
   end

   // ****************************************************************
   // sample tick interrupt and reset gating
   // ****************************************************************
   // interrupts stay held off until the delay after reset has run out
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         dly_q    <= DLY_ZERO;
         irq_en_q <= 1'b0;
      end else if (!irq_en_q) begin
         dly_q    <= dly_q + DLY_ONE;
         irq_en_q <= (dly_q == RST_DLY_LAST);   // [R11]
      end
   end

   // divide the clock down to the transfer-period rate
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         div_q  <= DIV_ZERO;
         tick_q <= 1'b0;
      end else begin
         div_q  <= (div_q == TICK_DIV_LAST) ? DIV_ZERO : div_q + DIV_ONE;  // [R10]
         tick_q <= irq_en_q & (div_q == TICK_DIV_LAST);                    // [R10] [R11]
      end
   end

   assign BUS.sample_tick_interrupt = tick_q;
   assign TICK_IRQ                  = tick_q;

   // ****************************************************************
   // boot straps
   // ****************************************************************
   // caught once when the gating delay ends; processors 2 to 4 load from
   // processor 1 over their host ports, processor 1 follows its strap
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         BOOT_MODE_P234 <= BOOT_MODE_NONE;
         P1_BOOT_HOST   <= 1'b0;
         BOOT_DONE      <= 1'b0;
      end else if (irq_en_q && !BOOT_DONE) begin
         BOOT_MODE_P234 <= BOOT_MODE_HOST;      // [R11] [R13]
         P1_BOOT_HOST   <= P1_BOOT_HOST_SEL;    // [R12]
         BOOT_DONE      <= 1'b1;
      end
   end

endmodule

// [arbiter_logic_device.sv]
// shared data bus arbiter for up to four signal processors
//
// Function
// R1: one shared 24-bit bus, only grantee drives
// R2: processors supply grant, request and ready lines
// R3: normal phase grants by priority 1 to 4
// R4: no request parks the bus on processor 1
// R5: transfer phase waits for all present ready
// R6: then serves processors 2, 3, 4, 1
// R7: absent processors 3, 4 never awaited or granted
// R8: host acknowledge pin echoes own request line
// R9: clocked by processor 1 processing clock
// R10: 16 kHz common tick starts each transfer
// R11: interrupts gated with reset plus 1 us
// R12: processor 1 boot source set at reset
// R13: processors 2-4 boot over shared host ports
// R14: one grant only, never snatched while held
// R15: after reset, normal phase, processor 1 granted
`timescale 1ns/1ns
module arbiter_logic_device
   import arb_pkg::*;
(
   input  wire logic                REF_CLK,
   input  wire logic                RST_N,
   dsp_bus_if.arbiter               BUS,
   input  wire logic                FIT3_SEL,
   input  wire logic                FIT4_SEL,
   output logic                     XFER_PHASE,
   output logic                     WAITING_READY,
   output logic      [SLOT_W-1:0]   BUS_OWNER,
   output logic                     OWNER_VALID
);

   // ****************************************************************
   // declarations
   // ****************************************************************
   arb_state_e              state_q;
   arb_state_e              state_d;
   logic [NUM_PROC-1:0]     grant_q;
   logic [NUM_PROC-1:0]     grant_d;
   logic [SLOT_W-1:0]       slot_q;
   logic [SLOT_W-1:0]       slot_d;
   logic [1:0]              fit_meta_q;
   logic [1:0]              fit_q;
   logic                    tick_prev_q;
   logic                    pend_q;
   logic                    pend_clr;
   logic                    tick_rise;
   logic [NUM_PROC-1:0]     fitted;
   logic [NUM_PROC-1:0]     req;
   logic [NUM_PROC-1:0]     rdy;
   logic                    any_ack;
   logic                    all_ready;
   logic [NUM_PROC-1:0]     prio_pick;
   logic [NUM_PROC-1:0]     slot_target;

   // ****************************************************************
   // helpers
   // ****************************************************************
   // processor index served in a given slot
   function automatic logic [SLOT_W-1:0] slot_proc(input logic [SLOT_W-1:0] s);
      logic [SLOT_W-1:0] p;
      p = IDX_P1;
      unique case (s)
         2'h0: p = IDX_P2;
         2'h1: p = IDX_P3;
         2'h2: p = IDX_P4;
         2'h3: p = IDX_P1;
      endcase
      return p;
   endfunction

   // next slot holding a fitted processor; the last slot is always fitted
   function automatic logic [SLOT_W-1:0] next_slot(input logic [SLOT_W-1:0] s,
                                                   input logic [NUM_PROC-1:0] f);
      logic [SLOT_W-1:0] n;
      n = s;
      for (int k = 0; k < NUM_PROC; k++) begin
         if (n != SLOT_LAST) begin
            n = n + SLOT_STEP;
            if (f[slot_proc(n)]) begin
               break;
            end
         end
      end
      return n;
   endfunction

   // one-hot to index for the owner report
   function automatic logic [SLOT_W-1:0] owner_index(input logic [NUM_PROC-1:0] g);
      logic [SLOT_W-1:0] idx;
      idx = IDX_P1;
      for (int k = 0; k < NUM_PROC; k++) begin
         if (g[k]) begin
            idx = SLOT_W'(k);
         end
      end
      return idx;
   endfunction

   // ****************************************************************
   // fitted-select synchroniser
   // ****************************************************************
   // switch inputs come from outside the clock domain
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         fit_meta_q <= 2'h0;
         fit_q      <= 2'h0;
      end else begin
         fit_meta_q <= {FIT4_SEL, FIT3_SEL};
         fit_q      <= fit_meta_q;
      end
   end

   // processors 1 and 2 are always present
   assign fitted = {fit_q[1], fit_q[0], 1'b1, 1'b1};                 // [R7]

   // absent processors are masked out of the request and ready decisions
   assign req       = BUS.ownership_request_line & fitted;           // [R2] [R7]
   assign rdy       = BUS.transfer_ready_line & fitted;              // [R2] [R7]
   assign any_ack   = |BUS.grant_state_line;
   assign all_ready = &(rdy | ~fitted);                              // [R5] [R7]

   // ****************************************************************
   // transfer period start
   // ****************************************************************
   // the tick comes from logic on this clock, so no synchroniser;
   // a tick landing as the pending flag clears is kept, set wins
   assign tick_rise = BUS.sample_tick_interrupt & ~tick_prev_q;
   assign pend_clr  = (state_q == ST_NORMAL) && (state_d == ST_WAIT);

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         tick_prev_q <= 1'b0;
         pend_q      <= 1'b0;
      end else begin
         tick_prev_q <= BUS.sample_tick_interrupt;
         if (tick_rise) begin
            pend_q <= 1'b1;                                          // [R10]
         end else if (pend_clr) begin
            pend_q <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // priority pick
   // ****************************************************************
   // lowest index wins; nobody asking parks on processor 1
   always_comb begin
      prio_pick = GRANT_P1;                                          // [R4]
      for (int i = NUM_PROC - 1; i >= 0; i--) begin
         if (req[i]) begin
            prio_pick = NUM_PROC'(GRANT_P1 << i);                    // [R3]
         end
      end
   end

   assign slot_target = NUM_PROC'(GRANT_P1 << slot_proc(slot_q));   // [R6]

   // ****************************************************************
   // arbitration state machine
   // ****************************************************************
   // a new grant is only issued once the bus is idle and every grant
   // echo has fallen, which costs a turnaround cycle but guarantees
   // two processors never drive together
   always_comb begin
      state_d = state_q;
      grant_d = grant_q;
      slot_d  = slot_q;
      unique case (state_q)
         ST_NORMAL: begin
            if (grant_q == GRANT_NONE) begin
               if (!any_ack) begin
                  grant_d = prio_pick;                               // [R3] [R14]
               end
            end else if (!(|(grant_q & req))) begin
               // holder has let go, only now may the bus move  [R14]
               if (pend_q) begin
                  grant_d = GRANT_NONE;                              // [R5]
                  state_d = ST_WAIT;
               end else if (prio_pick != grant_q) begin
                  grant_d = GRANT_NONE;                              // [R14]
               end
            end
         end
         ST_WAIT: begin
            if (all_ready && !any_ack) begin
               state_d = ST_SERVE;                                   // [R5]
               slot_d  = SLOT_FIRST;                                 // [R6]
            end
         end
         ST_SERVE: begin
            if (grant_q == GRANT_NONE) begin
               if (!any_ack) begin
                  grant_d = slot_target;                             // [R6] [R14]
               end
            end else if (!(|(grant_q & rdy))) begin
               grant_d = GRANT_NONE;                                 // [R14]
               if (slot_q == SLOT_LAST) begin
                  state_d = ST_NORMAL;
               end else begin
                  slot_d = next_slot(slot_q, fitted);                // [R6] [R7]
               end
            end
         end
      endcase
   end

   // state, grant and slot registers; reset parks on processor 1
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         state_q <= ST_NORMAL;                                       // [R15]
         grant_q <= GRANT_P1;                                        // [R15]
         slot_q  <= SLOT_FIRST;
      end else begin
         state_q <= state_d;                                         // [R9]
         grant_q <= grant_d;
         slot_q  <= slot_d;
      end
   end

   assign BUS.bus_grant = grant_q;                                   // [R1]

   // ****************************************************************
   // status outputs
   // ****************************************************************
   // taken from the next-state values so they line up with the grant
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         XFER_PHASE    <= 1'b0;
         WAITING_READY <= 1'b0;
         BUS_OWNER     <= IDX_P1;
         OWNER_VALID   <= 1'b1;
      end else begin
         XFER_PHASE    <= (state_d != ST_NORMAL);
         WAITING_READY <= (state_d == ST_WAIT);
         BUS_OWNER     <= owner_index(grant_d);
         OWNER_VALID   <= (grant_d != GRANT_NONE);
      end
   end

endmodule

// [four_dsp_bus_arbiter_sva.sv]
// concurrent checks on the shared processor bus
`timescale 1ns/1ns
module four_dsp_bus_arbiter_sva
   import arb_pkg::*;
(
   input  wire logic                REF_CLK,
   input  wire logic                RST_N,
   input  wire logic [NUM_PROC-1:0] bus_grant,
   input  wire logic [NUM_PROC-1:0] grant_state_line,
   input  wire logic [NUM_PROC-1:0] ownership_request_line,
   input  wire logic [NUM_PROC-1:0] transfer_ready_line,
   input  wire logic                sample_tick_interrupt,
   input  wire logic [NUM_PROC-1:0] data_oe,
   input  wire logic                XFER_PHASE,
   input  wire logic                WAITING_READY
);

   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RST_N);

   // ****************
   // sequences
   // ****************
   // non-parked holder let go
   sequence holder_released;
      (bus_grant[3:1] & ~ownership_request_line[3:1] & ~transfer_ready_line[3:1]) != 3'h0;
   endsequence

   // idle, turned round, no fresh tick
   sequence bus_quiet;
      !XFER_PHASE && bus_grant == GRANT_NONE && grant_state_line == GRANT_NONE &&
      ownership_request_line == GRANT_NONE && !sample_tick_interrupt && !$past(sample_tick_interrupt);
   endsequence

   // ****************
   // assertions
   // ****************
   chk_grant_onehot: assert property ($onehot0(bus_grant))
      else $error("two grants");
   chk_driver_granted: assert property ((data_oe & ~grant_state_line) == GRANT_NONE)
      else $error("drive without grant");
   chk_no_snatch: assert property ((bus_grant & ownership_request_line & transfer_ready_line) != GRANT_NONE
      |=> $stable(bus_grant))
      else $error("grant taken while held");
   chk_grant_turnaround: assert property ((bus_grant != GRANT_NONE && $past(bus_grant) == GRANT_NONE)
      |-> $past(grant_state_line) == GRANT_NONE)
      else $error("grant before echo fell");
   chk_release_drop: assert property (holder_released |=> bus_grant[3:1] == 3'h0)
      else $error("grant kept after release");
   chk_park_proc1: assert property (bus_quiet |=> bus_grant == GRANT_P1)
      else $error("idle bus not parked");
   chk_wait_no_grant: assert property (WAITING_READY |-> bus_grant == GRANT_NONE)
      else $error("grant while waiting");
   chk_wait_all_ready: assert property ($fell(WAITING_READY) |-> $past(transfer_ready_line[1:0]) == 2'h3)
      else $error("wait left early");
   chk_serve_first: assert property ($fell(WAITING_READY) && XFER_PHASE |-> ##[0:2] bus_grant == 4'h2)
      else $error("service not led by processor 2");
   chk_tick_pulse: assert property (sample_tick_interrupt |=> !sample_tick_interrupt)
      else $error("tick too long");

endmodule

// [tb_four_dsp_bus_arbiter.sv]
// self-checking bench for the bus arbiter
`timescale 1ns/1ns
module tb_four_dsp_bus_arbiter;
   import arb_pkg::*;

   localparam int TIMEOUT_CYC = 6000;
   logic                       ref_clk;
   logic                       rst_n;
   logic                       fit3_sel;
   logic                       fit4_sel;
   logic [NUM_PROC-1:0]        req;
   logic [NUM_PROC-1:0]        xfer_rdy;
   logic [NUM_PROC-1:0]        wr_en;
   logic [NUM_PROC*DATA_W-1:0] wr_data;
   logic                       boot_host_sel;
   logic                       xfer_phase;
   logic                       waiting_ready;
   logic [SLOT_W-1:0]          bus_owner;
   logic                       owner_valid;
   logic [NUM_PROC-1:0]        host_ack;
   logic [DATA_W-1:0]          rd_data;
   logic                       tick_irq;
   logic [3:0]                 boot_mode;
   logic                       p1_boot_host;
   logic                       boot_done;
   int                         miscompares;
   int                         cmp_count;
   int                         cycles;
   int                         last_tick;

   dsp_bus_if bus_if ();

   arbiter_logic_device arbiter_logic_device_inst (.REF_CLK(ref_clk), .RST_N(rst_n), .BUS(bus_if.arbiter),
      .FIT3_SEL(fit3_sel), .FIT4_SEL(fit4_sel), .XFER_PHASE(xfer_phase), .WAITING_READY(waiting_ready),
      .BUS_OWNER(bus_owner), .OWNER_VALID(owner_valid));

   dsp_cores_end dsp_cores_end_inst (.REF_CLK(ref_clk), .RST_N(rst_n), .BUS(bus_if.cores), .REQ(req),
      .XFER_RDY(xfer_rdy), .WR_EN(wr_en), .WR_DATA(wr_data), .P1_BOOT_HOST_SEL(boot_host_sel),
      .HOST_ACK(host_ack), .RD_DATA(rd_data), .TICK_IRQ(tick_irq), .BOOT_MODE_P234(boot_mode),
      .P1_BOOT_HOST(p1_boot_host), .BOOT_DONE(boot_done));

   four_dsp_bus_arbiter_sva four_dsp_bus_arbiter_sva_inst (.REF_CLK(ref_clk), .RST_N(rst_n),
      .bus_grant(bus_if.bus_grant), .grant_state_line(bus_if.grant_state_line),
      .ownership_request_line(bus_if.ownership_request_line), .transfer_ready_line(bus_if.transfer_ready_line),
      .sample_tick_interrupt(bus_if.sample_tick_interrupt), .data_oe(bus_if.data_oe),
      .XFER_PHASE(xfer_phase), .WAITING_READY(waiting_ready));

   // ****************
   // clock, timeout and shared tasks
   // ****************
   // 20 mhz stand-in for the processing clock
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   // a hang ends here as a mismatch
   always @(posedge ref_clk) begin
      cycles = cycles + 1;
      if (cycles == TIMEOUT_CYC) begin
         miscompares++;
         print_verdict();
      end
   end

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // wait for a new grant, check owner and bus data
   task automatic next_grant(input logic [3:0] prev, input logic [3:0] exp);
      logic [DATA_W-1:0] exp_d;
      int                n;
      exp_d = '0;
      n = 0;
      @(negedge ref_clk);
      while ((bus_if.bus_grant === GRANT_NONE || bus_if.bus_grant === prev) && n < 40) begin
         @(negedge ref_clk);
         n++;
      end
      check("grant", 32'(exp), 32'(bus_if.bus_grant));
      for (int i = 0; i < NUM_PROC; i++) begin
         if (exp[i]) exp_d = wr_data[i*DATA_W +: DATA_W];
      end
      repeat (3) @(negedge ref_clk);
      check("bus data", 32'(exp_d), 32'(rd_data));
   endtask

   task automatic set_req(input logic [3:0] off, input logic [3:0] on);
      @(posedge ref_clk);
      req <= (req & ~off) | on;
   endtask

   // ****************
   // scenarios
   // ****************
   // reset values and boot straps
   task automatic do_reset(input logic strap);
      @(posedge ref_clk);
      rst_n <= 1'b0;
      boot_host_sel <= strap;
      repeat (16) @(posedge ref_clk);
      check("grant in reset", 32'(GRANT_P1), 32'(bus_if.bus_grant));
      check("phase in reset", 32'h0, 32'(xfer_phase));
      rst_n <= 1'b1;
      repeat (5) @(negedge ref_clk);
      check("boot mode early", 32'(BOOT_MODE_NONE), 32'(boot_mode));
      repeat (20) @(negedge ref_clk);
      check("boot mode", 32'(BOOT_MODE_HOST), 32'(boot_mode));
      check("boot done", 32'h1, 32'(boot_done));
      check("boot strap", 32'(strap), 32'(p1_boot_host));
      check("grant after reset", 32'(GRANT_P1), 32'(bus_if.bus_grant));
   endtask

   // fixed priority; processor 2 beats waiting 4
   task automatic t_priority();
      set_req(4'h0, 4'hf);
      next_grant(GRANT_NONE, 4'h1);
      check("host ack", 32'(req), 32'(host_ack));
      set_req(4'h1, 4'h0);
      next_grant(4'h1, 4'h2);
      set_req(4'h2, 4'h0);
      next_grant(4'h2, 4'h4);
      set_req(4'h4, 4'h2);
      next_grant(4'h4, 4'h2);
      set_req(4'h2, 4'h0);
      next_grant(4'h2, 4'h8);
      check("host ack", 32'(req), 32'(host_ack));
      set_req(4'h8, 4'h0);
      repeat (6) @(negedge ref_clk);
      check("park", 32'(GRANT_P1), 32'(bus_if.bus_grant));
   endtask

   // absent processor 4 never granted
   task automatic t_absent();
      @(posedge ref_clk);
      fit4_sel <= 1'b0;
      repeat (4) @(posedge ref_clk);
      set_req(4'h0, 4'h8);
      repeat (8) @(negedge ref_clk);
      check("absent grant", 32'(GRANT_P1), 32'(bus_if.bus_grant));
      check("owner index", 32'(IDX_P1), 32'(bus_owner));
      check("owner valid", 32'h1, 32'(owner_valid));
      set_req(4'h0, 4'h4);
      next_grant(GRANT_P1, 4'h4);
      set_req(4'h4, 4'h0);
      repeat (6) @(negedge ref_clk);
      check("absent skipped", 32'(GRANT_P1), 32'(bus_if.bus_grant));
      set_req(4'h8, 4'h0);
      fit4_sel <= 1'b1;
   endtask

   // tick transfer: hold off, then serve in order
   task automatic run_transfer(input logic f3, input logic [15:0] order, input int slots);
      logic [3:0] prev;
      logic [3:0] g;
      int         n;
      n = 0;
      @(posedge ref_clk);
      fit3_sel <= f3;
      xfer_rdy <= {1'b0, f3, 2'h3};
      while (tick_irq !== 1'b1 && n < 1400) begin
         @(negedge ref_clk);
         n++;
      end
      check("tick seen", 32'h1, 32'(tick_irq));
      if (last_tick != 0) check("tick gap", 32'(TICK_DIV_CYC), 32'(cycles - last_tick));
      last_tick = cycles;
      repeat (10) @(negedge ref_clk);
      check("waiting", 32'h1, 32'(waiting_ready));
      check("held off", 32'(GRANT_NONE), 32'(bus_if.bus_grant));
      @(posedge ref_clk);
      xfer_rdy[3] <= 1'b1;
      prev = GRANT_NONE;
      for (int k = 0; k < slots; k++) begin
         g = order[4*k +: 4];
         next_grant(prev, g);
         prev = g;
         @(posedge ref_clk);
         xfer_rdy <= xfer_rdy & ~g;
      end
      repeat (8) @(negedge ref_clk);
      check("phase over", 32'h0, 32'(xfer_phase));
      check("park after", 32'(GRANT_P1), 32'(bus_if.bus_grant));
   endtask

   // ****************
   // main sequence
   // ****************
   initial begin
      rst_n = 1'b0;
      fit3_sel = 1'b1;
      fit4_sel = 1'b1;
      req = 4'h0;
      xfer_rdy = 4'h0;
      wr_en = 4'hf;
      // disjoint, so a second driver shows
      wr_data = {24'h888888, 24'h444444, 24'h222222, 24'h111111};
      boot_host_sel = 1'b0;
      miscompares = 0;
      cmp_count = 0;
      cycles = 0;
      last_tick = 0;
      do_reset(1'b0);
      t_priority();
      t_absent();
      run_transfer(1'b1, 16'h1842, 4);
      run_transfer(1'b0, 16'h0182, 3);
      do_reset(1'b1);
      print_verdict();
   end

endmodule
